// File: hw/rxirq_defs.vh
`ifndef RXIRQ_DEFS_VH
`define RXIRQ_DEFS_VH
// register addresses
`define RXIRQ_ADDR_MODE      8'h1E
`define RXIRQ_ADDR_ISTAT     8'h20
`define RXIRQ_ADDR_IMASK     8'h21
`define RXIRQ_ADDR_IMODE_HI  8'h22
`define RXIRQ_ADDR_IMODE_LO  8'h23
`define RXIRQ_ADDR_CBUF_CTL  8'h24
`define RXIRQ_ADDR_CHSTAT    8'h25
`define RXIRQ_ADDR_FAULT     8'h26
`define RXIRQ_ADDR_FAULT_EN  8'h27
// reset values
`define RXIRQ_RST_MODE       8'h00
`define RXIRQ_RST_IMASK      8'h00
`define RXIRQ_RST_IMODE      8'h00
`define RXIRQ_RST_CBUF_CTL   8'h40
`define RXIRQ_RST_FAULT_EN   8'h00
// interrupt source positions
`define RXIRQ_SRC_UNLOCK     7
`define RXIRQ_SRC_QCH        5
`define RXIRQ_SRC_DETC       4
`define RXIRQ_SRC_DETU       3
`define RXIRQ_SRC_OVFL       1
`define RXIRQ_SRC_RFAULT     0
`define RXIRQ_SRC_USED       8'hBB
// receiver error positions
`define RXIRQ_ERR_SUB_CHK    6
`define RXIRQ_ERR_BLK_CHK    5
`define RXIRQ_ERR_UNLOCK     4
`define RXIRQ_ERR_VALID      3
`define RXIRQ_ERR_TRUST      2
`define RXIRQ_ERR_LINE       1
`define RXIRQ_ERR_ODD_EVEN   0
`define RXIRQ_ERR_USED       8'h7F
`define RXIRQ_ERR_NOCRC      8'h1F
// mode register fields
`define RXIRQ_MODE_PIN_HI    3
`define RXIRQ_MODE_PIN_LO    2
`define RXIRQ_MODE_HOLD_HI   1
`define RXIRQ_MODE_HOLD_LO   0
// buffer control fields
`define RXIRQ_CBUF_LOCK_HI   7
`define RXIRQ_CBUF_LOCK_LO   6
`define RXIRQ_CBUF_CONTENT   2
`define RXIRQ_CBUF_WIDTH     1
`define RXIRQ_CBUF_SIDE      0
`define RXIRQ_CBUF_USED      8'hC7
// trigger modes
`define RXIRQ_TRIG_RISE      2'b00
`define RXIRQ_TRIG_FALL      2'b01
`define RXIRQ_TRIG_LEVEL     2'b10
// pin styles
`define RXIRQ_PIN_ACT_HI     2'b00
`define RXIRQ_PIN_ACT_LO     2'b01
`define RXIRQ_PIN_OD_LO      2'b10
// sample hold codes
`define RXIRQ_HOLD_LAST      2'b00
`define RXIRQ_HOLD_ZERO      2'b01
`define RXIRQ_HOLD_PASS      2'b10
`define RXIRQ_SAMPLE_W       24
`endif

// File: hw/rxirq_trig.v
`timescale 1ns/1ps
`include "rxirq_defs.vh"
// per-source trigger detector: one pulse or level per source
module rxirq_trig (
   input  wire       clk_sys_i,
   input  wire       rst_i,
   input  wire       ce_i,
   input  wire [7:0] cond_i,
   input  wire [7:0] mode_hi_i,
   input  wire [7:0] mode_lo_i,
   output wire [7:0] event_o
);
   reg [7:0] prev_q;

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         prev_q <= 8'h00;
      end else if (ce_i) begin
         prev_q <= cond_i;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_src
         wire [1:0] mode_w;
         reg        ev_r;
         assign mode_w = {mode_hi_i[g], mode_lo_i[g]};
         always @* begin
            case (mode_w)
               `RXIRQ_TRIG_RISE:  ev_r = cond_i[g] & ~prev_q[g];
               `RXIRQ_TRIG_FALL:  ev_r = ~cond_i[g] & prev_q[g];
               `RXIRQ_TRIG_LEVEL: ev_r = cond_i[g];
               default:           ev_r = 1'b0;
            endcase
         end
         assign event_o[g] = ev_r;
      end
   endgenerate
endmodule

// File: hw/rxirq_top.v
`timescale 1ns/1ps
`include "rxirq_defs.vh"
module rxirq_top (
   input  wire        clk_sys_i,
   input  wire        rst_i,
   input  wire        ce_i,
   // register port
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   input  wire [7:0]  reg_addr_i,
   input  wire [7:0]  reg_wdata_i,
   output reg  [7:0]  reg_rdata_o,
   // interrupt pin
   output reg         irq_o,
   output reg         irq_oe_o,
   // interrupt sources other than receiver fault and PLL unlock
   input  wire        cstat_xfer_i,
   input  wire        udata_xfer_i,
   input  wire        subcode_new_i,
   input  wire        adc_clip_i,
   // receiver status from the datapath
   input  wire        pll_unlocked_i,
   input  wire        subframe_end_i,
   input  wire        qblock_end_i,
   input  wire        csblock_end_i,
   input  wire        validity_i,
   input  wire        line_code_err_i,
   input  wire        parity_err_i,
   input  wire        subcode_check_error_err_i,
   input  wire        cscrc_err_i,
   input  wire [3:0]  aux_width_a_i,
   input  wire [3:0]  aux_width_b_i,
   input  wire [1:0]  pro_a_b_i,
   input  wire [1:0]  nonpcm_a_b_i,
   input  wire [1:0]  copy_a_b_i,
   input  wire [1:0]  first_copy_a_b_i,
   input  wire [1:0]  cat_general_a_b_i,
   input  wire        rx_in_use_i,
   // audio sample path
   input  wire        sample_stb_i,
   input  wire [23:0] sample_i,
   output reg  [23:0] sample_o,
   output reg         sample_stb_o,
   // buffer and lock controls to the datapath
   output reg  [1:0]  lock_algorithm_o,
   output reg         buffer_content_select_o,
   output reg         cbuf_access_width_o,
   output reg         status_side_select_o
);

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   // only the second stage feeds logic
   reg  [5:0] sync1_q;
   reg  [5:0] sync2_q;
   wire [5:0] async_w;
   assign async_w = {cstat_xfer_i, udata_xfer_i, subcode_new_i, adc_clip_i,
                     pll_unlocked_i, rx_in_use_i};
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         sync1_q <= 6'h00;
         sync2_q <= 6'h00;
      end else if (ce_i) begin
         sync1_q <= async_w;
         sync2_q <= sync1_q;
      end
   end
   wire s_cstat   = sync2_q[5];
   wire s_udata   = sync2_q[4];
   wire s_subcode = sync2_q[3];
   wire s_clip    = sync2_q[2];
   wire s_unlock  = sync2_q[1];
   wire s_in_use  = sync2_q[0];

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   reg [7:0] mode_q;
   reg [7:0] imask_q;
   reg [7:0] imode_hi_q;
   reg [7:0] imode_lo_q;
   reg [7:0] cbuf_ctl_q;
   reg [7:0] fault_en_q;

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         mode_q      <= `RXIRQ_RST_MODE;
         imask_q     <= `RXIRQ_RST_IMASK;
         imode_hi_q  <= `RXIRQ_RST_IMODE;
         imode_lo_q  <= `RXIRQ_RST_IMODE;
         cbuf_ctl_q  <= `RXIRQ_RST_CBUF_CTL;
         fault_en_q  <= `RXIRQ_RST_FAULT_EN;
      end else if (ce_i && reg_wr_i) begin
         // reserved bits are stored as zero, except in the mode register, which keeps all eight bits
         case (reg_addr_i)
            `RXIRQ_ADDR_MODE:      mode_q      <= reg_wdata_i;
            `RXIRQ_ADDR_IMASK:     imask_q     <= reg_wdata_i & `RXIRQ_SRC_USED;
            `RXIRQ_ADDR_IMODE_HI:  imode_hi_q  <= reg_wdata_i & `RXIRQ_SRC_USED;
            `RXIRQ_ADDR_IMODE_LO:  imode_lo_q  <= reg_wdata_i & `RXIRQ_SRC_USED;
            `RXIRQ_ADDR_CBUF_CTL:  cbuf_ctl_q  <= reg_wdata_i & `RXIRQ_CBUF_USED;
            `RXIRQ_ADDR_FAULT_EN:  fault_en_q  <= reg_wdata_i & `RXIRQ_ERR_USED;
            default:               mode_q      <= mode_q;
         endcase
      end
   end

   // fields of the mode and buffer control registers
   wire [1:0] pin_style = mode_q[`RXIRQ_MODE_PIN_HI:`RXIRQ_MODE_PIN_LO];
   wire [1:0] hold_sel  = mode_q[`RXIRQ_MODE_HOLD_HI:`RXIRQ_MODE_HOLD_LO];
   wire       side_b    = cbuf_ctl_q[`RXIRQ_CBUF_SIDE];

   // ------------------------------------------------------------
   // receiver error register
   // ------------------------------------------------------------
   reg [7:0] fault_raw_q;
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         fault_raw_q <= 8'h00;
      end else if (ce_i) begin
         fault_raw_q[`RXIRQ_ERR_UNLOCK] <= s_unlock;
         if (qblock_end_i) begin
            fault_raw_q[`RXIRQ_ERR_SUB_CHK] <= subcode_check_error_err_i;
         end
         if (csblock_end_i) begin
            fault_raw_q[`RXIRQ_ERR_BLK_CHK] <= cscrc_err_i;
         end
         if (subframe_end_i) begin
            fault_raw_q[`RXIRQ_ERR_VALID]    <= validity_i;
            fault_raw_q[`RXIRQ_ERR_TRUST]    <= s_unlock | line_code_err_i;
            fault_raw_q[`RXIRQ_ERR_LINE]     <= line_code_err_i;
            fault_raw_q[`RXIRQ_ERR_ODD_EVEN] <= parity_err_i;
         end
      end
   end
   wire [7:0] fault_vis = fault_raw_q & fault_en_q;
   wire       rfault    = |fault_vis;
   wire       spoil     = |(fault_vis & `RXIRQ_ERR_NOCRC);

   // ------------------------------------------------------------
   // interrupt sources and trigger detection
   // ------------------------------------------------------------
   wire [7:0] cond_w;
   wire [7:0] event_w;
   assign cond_w = {s_unlock, 1'b0, s_subcode, s_cstat, s_udata, 1'b0, s_clip, rfault};

   rxirq_trig rxirq_trig_inst (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .cond_i    (cond_w),
      .mode_hi_i (imode_hi_q),
      .mode_lo_i (imode_lo_q),
      .event_o   (event_w)
   );

   // ------------------------------------------------------------
   // sticky status, clear on read
   // ------------------------------------------------------------
   reg  [7:0] istat_q;
   wire       istat_rd = reg_rd_i && (reg_addr_i == `RXIRQ_ADDR_ISTAT);
   wire [7:0] ev_masked = event_w & imask_q;
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         istat_q <= 8'h00;
      end else if (ce_i) begin
         if (istat_rd) begin
            istat_q <= ev_masked;
         end else begin
            istat_q <= (istat_q | ev_masked) & imask_q;
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt pin
   // ------------------------------------------------------------
   wire irq_active = |istat_q;
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         irq_o    <= 1'b0;
         irq_oe_o <= 1'b1;
      end else if (ce_i) begin
         case (pin_style)
            `RXIRQ_PIN_ACT_HI: begin
               irq_o    <= irq_active;
               irq_oe_o <= 1'b1;
            end
            `RXIRQ_PIN_ACT_LO: begin
               irq_o    <= ~irq_active;
               irq_oe_o <= 1'b1;
            end
            `RXIRQ_PIN_OD_LO: begin
               irq_o    <= 1'b0;
               irq_oe_o <= irq_active;
            end
            // reserved style releases the pin
            default: begin
               irq_o    <= 1'b0;
               irq_oe_o <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // channel status decode
   // ------------------------------------------------------------
   reg [7:0] chstat_w;
   always @* begin
      chstat_w = 8'h00;
      chstat_w[7:4] = side_b ? aux_width_b_i : aux_width_a_i;
      chstat_w[3]   = pro_a_b_i[side_b];
      chstat_w[2]   = nonpcm_a_b_i[side_b];
      chstat_w[1]   = copy_a_b_i[side_b] | cat_general_a_b_i[side_b];
      chstat_w[0]   = first_copy_a_b_i[side_b];
      if (pro_a_b_i[side_b] || !s_in_use) begin
         chstat_w[1] = 1'b1;
         chstat_w[0] = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // register read
   // ------------------------------------------------------------
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (ce_i && reg_rd_i) begin
         case (reg_addr_i)
            `RXIRQ_ADDR_MODE:      reg_rdata_o <= mode_q;
            `RXIRQ_ADDR_ISTAT:     reg_rdata_o <= istat_q & imask_q;
            `RXIRQ_ADDR_IMASK:     reg_rdata_o <= imask_q;
            `RXIRQ_ADDR_IMODE_HI:  reg_rdata_o <= imode_hi_q;
            `RXIRQ_ADDR_IMODE_LO:  reg_rdata_o <= imode_lo_q;
            `RXIRQ_ADDR_CBUF_CTL:  reg_rdata_o <= cbuf_ctl_q;
            `RXIRQ_ADDR_CHSTAT:    reg_rdata_o <= chstat_w;
            `RXIRQ_ADDR_FAULT:     reg_rdata_o <= fault_vis;
            `RXIRQ_ADDR_FAULT_EN:  reg_rdata_o <= fault_en_q;
            default:               reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // controls to datapath
   // ------------------------------------------------------------
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         lock_algorithm_o        <= 2'b01;
         buffer_content_select_o <= 1'b0;
         cbuf_access_width_o     <= 1'b0;
         status_side_select_o    <= 1'b0;
      end else if (ce_i) begin
         lock_algorithm_o        <= cbuf_ctl_q[`RXIRQ_CBUF_LOCK_HI:`RXIRQ_CBUF_LOCK_LO];
         buffer_content_select_o <= cbuf_ctl_q[`RXIRQ_CBUF_CONTENT];
         cbuf_access_width_o     <= cbuf_ctl_q[`RXIRQ_CBUF_WIDTH];
         status_side_select_o    <= side_b;
      end
   end

   // ------------------------------------------------------------
   // audio sample hold
   // ------------------------------------------------------------
   reg [23:0] last_good_q;
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         last_good_q  <= 24'h000000;
         sample_o     <= 24'h000000;
         sample_stb_o <= 1'b0;
      end else if (ce_i) begin
         sample_stb_o <= sample_stb_i;
         if (sample_stb_i) begin
            if (!spoil) begin
               sample_o    <= sample_i;
               last_good_q <= sample_i;
            end else begin
               case (hold_sel)
                  `RXIRQ_HOLD_LAST: sample_o <= last_good_q;
                  `RXIRQ_HOLD_ZERO: sample_o <= 24'h000000;
                  // reserved code passes through
                  default:          sample_o <= sample_i;
               endcase
            end
         end
      end
   end
endmodule

// File: verif/rxirq_chk_assertions.sv
`timescale 1ns/1ps
module rxirq_chk (
   input wire       clk_sys_i,
   input wire       rst_i,
   input wire       ce_i,
   input wire       reg_wr_i,
   input wire       reg_rd_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire [7:0] reg_rdata_o,
   input wire       irq_oe_o,
   input wire       sample_stb_i,
   input wire       sample_stb_o,
   input wire [1:0] lock_algorithm_o,
   input wire       buffer_content_select_o,
   input wire       cbuf_access_width_o,
   input wire       status_side_select_o
);
   reg  [7:0] imask_q;
   reg  [7:0] emask_q;
   wire       rd = reg_rd_i && ce_i;
   wire       wr = reg_wr_i && ce_i;
   // -------------------------
   // shadow of the mask registers
   // -------------------------
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         imask_q <= 8'h00;
         emask_q <= 8'h00;
      end else begin
         if (wr && reg_addr_i == 8'h21)
            imask_q <= reg_wdata_i;
         if (wr && reg_addr_i == 8'h27)
            emask_q <= reg_wdata_i;
      end
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   AST_UNMAPPED_ZERO: assert property (rd && !(reg_addr_i == 8'h1E || reg_addr_i[7:3] == 5'h04)
      |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
   AST_IMASK_READ: assert property (rd && reg_addr_i == 8'h21
      |=> reg_rdata_o == ($past(imask_q) & 8'hBB)) else $error("mask readback wrong");
   AST_STATUS_MASKED: assert property (rd && reg_addr_i == 8'h20
      |=> (reg_rdata_o & ~($past(imask_q) & 8'hBB)) == 8'h00) else $error("masked status set");
   AST_FAULT_MASKED: assert property (rd && reg_addr_i == 8'h26
      |=> (reg_rdata_o & ~($past(emask_q) & 8'h7F)) == 8'h00) else $error("masked error shown");
   AST_RDATA_HOLD: assert property (!rd |=> $stable(reg_rdata_o))
      else $error("read data moved");
   AST_LOCK_FIELD: assert property (wr && reg_addr_i == 8'h24
      |=> ##1 lock_algorithm_o == $past(reg_wdata_i[7:6], 2)) else $error("lock field wrong");
   AST_CTRL_BITS: assert property (wr && reg_addr_i == 8'h24
      |=> ##1 {buffer_content_select_o, cbuf_access_width_o, status_side_select_o}
          == $past(reg_wdata_i[2:0], 2)) else $error("buffer control bits wrong");
   AST_SAMPLE_STB: assert property (sample_stb_i && ce_i |=> sample_stb_o)
      else $error("sample strobe lost");
   AST_PIN_DRIVE: assert property (wr && reg_addr_i == 8'h1E && !reg_wdata_i[3]
      ##1 !(wr && reg_addr_i == 8'h1E) |=> irq_oe_o) else $error("push-pull pin released");
   AST_RESET_STATE: assert property (disable iff (1'b0) rst_i
      |=> lock_algorithm_o == 2'b01 && irq_oe_o && reg_rdata_o == 8'h00)
      else $error("reset state wrong");
   COV_STATUS: cover property (rd && reg_addr_i == 8'h20 ##1 reg_rdata_o != 8'h00);
   COV_FAULT: cover property (rd && reg_addr_i == 8'h26 ##1 reg_rdata_o != 8'h00);
   COV_SAMPLE: cover property (sample_stb_o);
endmodule
bind rxirq_top rxirq_chk rxirq_chk_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .irq_oe_o(irq_oe_o),
   .sample_stb_i(sample_stb_i), .sample_stb_o(sample_stb_o),
   .lock_algorithm_o(lock_algorithm_o), .buffer_content_select_o(buffer_content_select_o),
   .cbuf_access_width_o(cbuf_access_width_o), .status_side_select_o(status_side_select_o));

// File: verif/test_rxirq_top.sv
`timescale 1ns/1ps
module test_rxirq_top;
   reg         clk, rst, ce, wr, rd, clip, unl, sfe, qbe, cbe, val, lce, pe, qce, cce;
   reg         inuse, sstb, cst, udt, sbc;
   reg  [7:0]  addr, wdata, junk;
   reg  [3:0]  auxa, auxb;
   reg  [1:0]  pro, npcm, cpy, fcopy, catg, sty;
   reg  [23:0] sin;
   wire [7:0]  rdata;
   wire [23:0] sout;
   wire [1:0]  lalg;
   wire        irq, irqoe, sstbo, bufsel, bwid, side;
   integer     err_count, num_checks;
   rxirq_top rxirq_top_inst (.clk_sys_i(clk), .rst_i(rst), .ce_i(ce), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .irq_o(irq), .irq_oe_o(irqoe), .cstat_xfer_i(cst), .udata_xfer_i(udt),
      .subcode_new_i(sbc), .adc_clip_i(clip), .pll_unlocked_i(unl), .subframe_end_i(sfe),
      .qblock_end_i(qbe), .csblock_end_i(cbe), .validity_i(val), .line_code_err_i(lce),
      .parity_err_i(pe), .subcode_check_error_err_i(qce), .cscrc_err_i(cce), .aux_width_a_i(auxa),
      .aux_width_b_i(auxb), .pro_a_b_i(pro), .nonpcm_a_b_i(npcm), .copy_a_b_i(cpy),
      .first_copy_a_b_i(fcopy), .cat_general_a_b_i(catg), .rx_in_use_i(inuse),
      .sample_stb_i(sstb), .sample_i(sin), .sample_o(sout), .sample_stb_o(sstbo),
      .lock_algorithm_o(lalg), .buffer_content_select_o(bufsel),
      .cbuf_access_width_o(bwid), .status_side_select_o(side));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   // -------------------------
   // shared tasks
   // -------------------------
   task chk(input [23:0] got, input [23:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task wr_reg(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk) #1 wr = 1;
         addr = a;
         wdata = d;
         @(posedge clk) #1 wr = 0;
      end
   endtask
   task rd_reg(input [7:0] a, output [7:0] d);
      begin
         @(posedge clk) #1 rd = 1;
         addr = a;
         @(posedge clk) #1 rd = 0;
         d = rdata;
      end
   endtask
   task rd_chk(input [7:0] a, input [7:0] e);
      begin
         rd_reg(a, junk);
         chk(junk, e);
      end
   endtask
   task sf;
      begin
         @(posedge clk) #1 sfe = 1;
         @(posedge clk) #1 sfe = 0;
         tick(4);
      end
   endtask
   task smp(input [23:0] d, input [23:0] e);
      begin
         @(posedge clk) #1 sstb = 1;
         sin = d;
         @(posedge clk) #1 sstb = 0;
         chk(sout, e);
      end
   endtask
   // clip source, bit 1; e_on after arrival, e_off after removal
   task trig(input [1:0] m, input [7:0] e_on, input [7:0] e_off);
      begin
         wr_reg(8'h22, {6'h00, m[1], 1'b0});
         wr_reg(8'h23, {6'h00, m[0], 1'b0});
         rd_reg(8'h20, junk);
         clip = 1;
         tick(6);
         if (sty == 2'b10)
            chk(irqoe, e_on[1]);
         else
            chk(irq, e_on[1] ^ sty[0]);
         rd_chk(8'h20, e_on);
         clip = 0;
         tick(6);
         rd_chk(8'h20, e_off);
      end
   endtask
   task results;
      begin
         $display("checks %0d errors %0d", num_checks, err_count);
         if (err_count == 0 && num_checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   initial begin
      #200000;
      err_count = err_count + 1;
      results;
   end
   // -------------------------
   // main sequence
   // -------------------------
   initial begin
      {rst, ce, wr, rd, clip, unl, sfe, qbe, cbe, val, lce, pe, qce, cce, sstb} = 15'h6000;
      {addr, wdata, sin, sty, cst, udt, sbc} = 45'h0;
      // side A general non-PCM, side B professional
      {auxa, auxb, pro, npcm, cpy, fcopy, catg, inuse} = {4'h8, 4'h3, 10'h241, 1'b1};
      err_count = 0;
      num_checks = 0;
      tick(20);
      rst = 0;
      chk(lalg, 2'b01);
      rd_chk(8'h24, 8'h40);
      rd_chk(8'h21, 8'h00);
      rd_chk(8'h22, 8'h00);
      rd_chk(8'h23, 8'h00);
      rd_chk(8'h27, 8'h00);
      rd_chk(8'h10, 8'h00);
      wr_reg(8'h21, 8'hFF);
      rd_chk(8'h21, 8'hBB);
      // a write while frozen is dropped
      ce = 0;
      wr_reg(8'h21, 8'h00);
      ce = 1;
      rd_chk(8'h21, 8'hBB);
      wr_reg(8'h22, 8'hFF);
      rd_chk(8'h22, 8'hBB);
      wr_reg(8'h24, 8'hFF);
      tick(1);
      chk({lalg, bufsel, bwid, side}, 5'h1F);
      rd_chk(8'h24, 8'hC7);
      wr_reg(8'h24, 8'h40);
      rd_chk(8'h25, 8'h86);
      wr_reg(8'h24, 8'h41);
      rd_chk(8'h25, 8'h3B);
      inuse = 0;
      wr_reg(8'h24, 8'h40);
      rd_chk(8'h25, 8'h87);
      inuse = 1;
      wr_reg(8'h21, 8'h02);
      trig(2'b00, 8'h02, 8'h00);
      trig(2'b01, 8'h00, 8'h02);
      trig(2'b10, 8'h02, 8'h02);
      sty = 2'b01;
      wr_reg(8'h1E, 8'h04);
      trig(2'b00, 8'h02, 8'h00);
      sty = 2'b10;
      wr_reg(8'h1E, 8'h08);
      trig(2'b00, 8'h02, 8'h00);
      sty = 2'b00;
      wr_reg(8'h1E, 8'h01);
      wr_reg(8'h21, 8'h00);
      trig(2'b00, 8'h00, 8'h00);
      wr_reg(8'h21, 8'hB8);
      {unl, cst, udt, sbc} = 4'hF;
      tick(6);
      chk(irq, 1'b1);
      rd_chk(8'h20, 8'hB8);
      {unl, cst, udt, sbc} = 4'h0;
      wr_reg(8'h21, 8'h01);
      wr_reg(8'h27, 8'h1F);
      rd_reg(8'h20, junk);
      lce = 1;
      val = 1;
      sf;
      rd_chk(8'h26, 8'h0E);
      rd_chk(8'h20, 8'h01);
      smp(24'h123456, 24'h000000);
      wr_reg(8'h1E, 8'h02);
      smp(24'h222222, 24'h222222);
      {lce, val} = 2'b00;
      sf;
      wr_reg(8'h1E, 8'h00);
      smp(24'hABCDEF, 24'hABCDEF);
      lce = 1;
      sf;
      smp(24'h111111, 24'hABCDEF);
      wr_reg(8'h1E, 8'h01);
      wr_reg(8'h27, 8'h01);
      rd_chk(8'h26, 8'h00);
      smp(24'h333333, 24'h333333);
      {lce, unl} = 2'b01;
      wr_reg(8'h27, 8'h14);
      sf;
      rd_chk(8'h26, 8'h14);
      unl = 0;
      sf;
      wr_reg(8'h27, 8'h60);
      rd_reg(8'h20, junk);
      {qce, cce} = 2'b11;
      @(posedge clk) #1 {qbe, cbe} = 2'b11;
      @(posedge clk) #1 {qbe, cbe} = 2'b00;
      {qce, cce} = 2'b00;
      tick(4);
      rd_chk(8'h26, 8'h60);
      rd_chk(8'h20, 8'h01);
      smp(24'h444444, 24'h444444);
      results;
   end
endmodule
